// >>> hdl/dbw_defs.svh
// Register numbers, field positions and codes of the break and watch unit.
// Assumes a word-wide register port addressed by register number.
//
// Contract
// [R1] Each control register holds an 8-bit thread enable field in bits 23:16 and a hit counts only for enabled threads.
// [R2] Bit 0 of each control register is the master enable and nothing triggers while it is clear.
// [R3] Instruction control bit 1 clear breaks on PC equal to the compare address and set breaks on PC different.
// [R4] There are four independent instruction breakpoints, each with its own control register.
// [R5] Each of four data watchpoints holds a first and a second 32-bit address writable in debug mode.
// [R6] Data control bit 2 set lets loads trigger the watchpoint and clear keeps loads from triggering it.
// [R7] Data control bit 1 clear needs conditions A and B, set needs A or B.
// [R8] Each of four resource watchpoints holds a 32-bit mask and a 32-bit value writable in debug mode.
// [R9] Resource control bit 1 clear fires on condition A and set fires on condition B.
// [R10] A satisfied enabled instruction breakpoint raises a debug interrupt on its thread; the unit drops hits while already halted in debug mode.
// [R11] A debug interrupt records cause 3, 4 or 5 for instruction, data or resource and the thread number.
// [R12] The index of the triggering comparator is recorded, the lowest one when several fire together.
// [R13] The effective address or the resource identifier of the trigger is captured for reading.
// [R14] Resource A is identifier AND mask equal to value AND mask, B its negation; data A and B compare to the two addresses.
// [R15] Reserved control bits read as zero and ignore writes, and control fields clear on reset.
`ifndef DBW_DEFS_SVH
`define DBW_DEFS_SVH
`define DBW_OFS_CAUSE 8'h15
`define DBW_OFS_DATA 8'h16
`define DBW_OFS_IB_ADDR 8'h30
`define DBW_OFS_IB_CTL 8'h40
`define DBW_OFS_DW_ADDR1 8'h50
`define DBW_OFS_DW_ADDR2 8'h60
`define DBW_OFS_DW_CTL 8'h70
`define DBW_OFS_RW_MASK 8'h80
`define DBW_OFS_RW_VALUE 8'h90
`define DBW_OFS_RW_CTL 8'h9c
`define DBW_OFS_IRQ_STAT 8'ha0
`define DBW_OFS_IRQ_MASK 8'ha1
`define DBW_BIT_EN 0
`define DBW_BIT_SENSE 1
`define DBW_BIT_LOAD 2
`define DBW_POS_THR 16
`define DBW_POS_IDX 16
`define DBW_POS_CTHR 8
`define DBW_IB_CTL_MASK 32'h00ff0003
`define DBW_DW_CTL_MASK 32'h00ff0007
`define DBW_RW_CTL_MASK 32'h00ff0003
`define DBW_CAUSE_WMASK 32'h0003ff07
`define DBW_CAUSE_IB 3'h3
`define DBW_CAUSE_DW 3'h4
`define DBW_CAUSE_RW 3'h5
`define DBW_RST_WORD 32'h00000000
`endif

// >>> hdl/dbw_pkg.sv
// Types of the break and watch unit.
// Assumes the constants header is included by each design file.
package dbw_pkg;
  typedef enum logic [1:0] {DBW_RUN = 2'b01, DBW_HALT = 2'b10} dbw_state_type;
  typedef logic [31:0] dbw_word_type;
  typedef logic [2:0] dbw_thread_type;
endpackage : dbw_pkg

// >>> hdl/dbw_unit.sv
// Breakpoint and watchpoint comparators with debug interrupt capture.
// Assumes core inputs and the register port are on REF_CLK.
`timescale 1ns/10ps
`include "dbw_defs.svh"
module dbw_unit (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire dbw_pkg::dbw_word_type WDATA,
  input wire logic WR,
  input wire logic RD,
  output dbw_pkg::dbw_word_type RDATA,
  input wire logic PC_VALID,
  input wire dbw_pkg::dbw_word_type PC,
  input wire dbw_pkg::dbw_thread_type PC_THREAD,
  input wire logic MEM_VALID,
  input wire dbw_pkg::dbw_word_type MEM_ADDR,
  input wire logic MEM_LOAD,
  input wire dbw_pkg::dbw_thread_type MEM_THREAD,
  input wire logic RES_VALID,
  input wire dbw_pkg::dbw_word_type RES_ID,
  input wire dbw_pkg::dbw_thread_type RES_THREAD,
  output logic DBG_INT,
  output logic DBG_MODE,
  output dbw_pkg::dbw_thread_type DBG_THREAD,
  output logic INT_OUT
);
  import dbw_pkg::*;

  function automatic logic [1:0] low_idx(input logic [3:0] h);
    low_idx = h[0] ? 2'h0 : h[1] ? 2'h1 : h[2] ? 2'h2 : 2'h3;
  endfunction : low_idx

  function automatic logic armed(input dbw_word_type c, input dbw_thread_type t);
    armed = c[`DBW_BIT_EN] & c[`DBW_POS_THR + 32'(t)];
  endfunction : armed

  dbw_word_type ib_addr_reg [4];
  dbw_word_type ib_ctl_reg [4];
  dbw_word_type dw_a1_reg [4];
  dbw_word_type dw_a2_reg [4];
  dbw_word_type dw_ctl_reg [4];
  dbw_word_type rw_mask_reg [4];
  dbw_word_type rw_val_reg [4];
  dbw_word_type rw_ctl_reg [4];
  dbw_word_type ib_addr_next [4];
  dbw_word_type ib_ctl_next [4];
  dbw_word_type dw_a1_next [4];
  dbw_word_type dw_a2_next [4];
  dbw_word_type dw_ctl_next [4];
  dbw_word_type rw_mask_next [4];
  dbw_word_type rw_val_next [4];
  dbw_word_type rw_ctl_next [4];
  dbw_word_type cause_reg;
  dbw_word_type cause_next;
  dbw_word_type data_reg;
  dbw_word_type data_next;
  dbw_word_type rdata_reg;
  dbw_word_type rdata_next;
  logic [2:0] stat_reg;
  logic [2:0] stat_next;
  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  logic irq_reg;
  logic irq_next;
  logic int_reg;
  logic int_next;
  dbw_thread_type thr_reg;
  dbw_thread_type thr_next;
  dbw_state_type state_reg;
  dbw_state_type state_next;
  logic [3:0] ib_hit;
  logic [3:0] dw_hit;
  logic [3:0] rw_hit;
  logic [2:0] ev;
  logic cond_a;
  logic cond_b;

  // Comparators
  always_comb begin
    cond_a = 1'b0;
    cond_b = 1'b0;
    for (int i = 0; i < 4; i++) begin
      // [R4] Four breakpoints
      // [R10] PC compare, [R3] sense
      ib_hit[i] = PC_VALID && armed(ib_ctl_reg[i], PC_THREAD) &&
                  ((PC == ib_addr_reg[i]) ^ ib_ctl_reg[i][`DBW_BIT_SENSE]);
      // [R14] Data conditions
      cond_a = MEM_ADDR == dw_a1_reg[i];
      cond_b = MEM_ADDR == dw_a2_reg[i];
      // [R7] And or or, [R6] loads gated, [R1] [R2] armed
      dw_hit[i] = MEM_VALID && armed(dw_ctl_reg[i], MEM_THREAD) &&
                  (!MEM_LOAD || dw_ctl_reg[i][`DBW_BIT_LOAD]) &&
                  (dw_ctl_reg[i][`DBW_BIT_SENSE] ? (cond_a | cond_b) : (cond_a & cond_b));
      // [R14] Masked resource compare, [R9] A or B
      rw_hit[i] = RES_VALID && armed(rw_ctl_reg[i], RES_THREAD) &&
                  (((RES_ID & rw_mask_reg[i]) == (rw_val_reg[i] & rw_mask_reg[i])) ^
                   rw_ctl_reg[i][`DBW_BIT_SENSE]);
    end
    ev = {|rw_hit, |dw_hit, |ib_hit};
  end

  // Registers, capture and state
  always_comb begin
    ib_addr_next = ib_addr_reg;
    ib_ctl_next = ib_ctl_reg;
    dw_a1_next = dw_a1_reg;
    dw_a2_next = dw_a2_reg;
    dw_ctl_next = dw_ctl_reg;
    rw_mask_next = rw_mask_reg;
    rw_val_next = rw_val_reg;
    rw_ctl_next = rw_ctl_reg;
    cause_next = cause_reg;
    data_next = data_reg;
    stat_next = stat_reg;
    mask_next = mask_reg;
    thr_next = thr_reg;
    state_next = state_reg;
    irq_next = 1'b0;
    rdata_next = `DBW_RST_WORD;
    if (WR) begin
      case (ADDR)
        `DBW_OFS_CAUSE: begin
          cause_next = WDATA & `DBW_CAUSE_WMASK;
          // Writing the cause register ends the debug session
          state_next = DBW_RUN;
        end
        `DBW_OFS_DATA: data_next = WDATA;
        `DBW_OFS_IRQ_STAT: stat_next = stat_reg & ~WDATA[2:0];
        `DBW_OFS_IRQ_MASK: mask_next = WDATA[2:0];
        default: begin
          // [R5] [R8] Address, mask and value words
          // [R15] Reserved bits dropped
          case ({ADDR[7:2], 2'h0})
            `DBW_OFS_IB_ADDR: ib_addr_next[ADDR[1:0]] = WDATA;
            `DBW_OFS_IB_CTL: ib_ctl_next[ADDR[1:0]] = WDATA & `DBW_IB_CTL_MASK;
            `DBW_OFS_DW_ADDR1: dw_a1_next[ADDR[1:0]] = WDATA;
            `DBW_OFS_DW_ADDR2: dw_a2_next[ADDR[1:0]] = WDATA;
            `DBW_OFS_DW_CTL: dw_ctl_next[ADDR[1:0]] = WDATA & `DBW_DW_CTL_MASK;
            `DBW_OFS_RW_MASK: rw_mask_next[ADDR[1:0]] = WDATA;
            `DBW_OFS_RW_VALUE: rw_val_next[ADDR[1:0]] = WDATA;
            `DBW_OFS_RW_CTL: rw_ctl_next[ADDR[1:0]] = WDATA & `DBW_RW_CTL_MASK;
            default: ;
          endcase
        end
      endcase
    end
    if (RD) begin
      case (ADDR)
        `DBW_OFS_CAUSE: rdata_next = cause_reg;
        `DBW_OFS_DATA: rdata_next = data_reg;
        `DBW_OFS_IRQ_STAT: rdata_next = {29'h0, stat_reg};
        `DBW_OFS_IRQ_MASK: rdata_next = {29'h0, mask_reg};
        default: begin
          case ({ADDR[7:2], 2'h0})
            `DBW_OFS_IB_ADDR: rdata_next = ib_addr_reg[ADDR[1:0]];
            `DBW_OFS_IB_CTL: rdata_next = ib_ctl_reg[ADDR[1:0]];
            `DBW_OFS_DW_ADDR1: rdata_next = dw_a1_reg[ADDR[1:0]];
            `DBW_OFS_DW_ADDR2: rdata_next = dw_a2_reg[ADDR[1:0]];
            `DBW_OFS_DW_CTL: rdata_next = dw_ctl_reg[ADDR[1:0]];
            `DBW_OFS_RW_MASK: rdata_next = rw_mask_reg[ADDR[1:0]];
            `DBW_OFS_RW_VALUE: rdata_next = rw_val_reg[ADDR[1:0]];
            `DBW_OFS_RW_CTL: rdata_next = rw_ctl_reg[ADDR[1:0]];
            default: rdata_next = `DBW_RST_WORD;
          endcase
        end
      endcase
    end
    // Hits while halted are dropped so the captured cause stays stable
    case (state_reg)
      DBW_RUN: begin
        if (|ev) begin
          irq_next = 1'b1;
          state_next = DBW_HALT;
          // [R11] Cause and thread, instruction first
          // [R12] Lowest index
          if (ev[0]) begin
            cause_next = {14'h0, low_idx(ib_hit), 5'h0, PC_THREAD, 5'h0, `DBW_CAUSE_IB};
            thr_next = PC_THREAD;
          end else if (ev[1]) begin
            cause_next = {14'h0, low_idx(dw_hit), 5'h0, MEM_THREAD, 5'h0, `DBW_CAUSE_DW};
            thr_next = MEM_THREAD;
            // [R13] Effective address
            data_next = MEM_ADDR;
          end else begin
            cause_next = {14'h0, low_idx(rw_hit), 5'h0, RES_THREAD, 5'h0, `DBW_CAUSE_RW};
            thr_next = RES_THREAD;
            // [R13] Resource identifier
            data_next = RES_ID;
          end
        end
      end
      DBW_HALT: ;
      default: state_next = DBW_RUN;
    endcase
    // Set wins over a clear in the same cycle
    if (state_reg == DBW_RUN) begin
      stat_next = stat_next | ev;
    end
    int_next = |(stat_next & mask_next);
  end

  // [R15] Control fields clear on reset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 4; i++) begin
        ib_addr_reg[i] <= `DBW_RST_WORD;
        ib_ctl_reg[i] <= `DBW_RST_WORD;
        dw_a1_reg[i] <= `DBW_RST_WORD;
        dw_a2_reg[i] <= `DBW_RST_WORD;
        dw_ctl_reg[i] <= `DBW_RST_WORD;
        rw_mask_reg[i] <= `DBW_RST_WORD;
        rw_val_reg[i] <= `DBW_RST_WORD;
        rw_ctl_reg[i] <= `DBW_RST_WORD;
      end
      cause_reg <= `DBW_RST_WORD;
      data_reg <= `DBW_RST_WORD;
      rdata_reg <= `DBW_RST_WORD;
      stat_reg <= 3'h0;
      mask_reg <= 3'h0;
      thr_reg <= 3'h0;
      irq_reg <= 1'b0;
      int_reg <= 1'b0;
      state_reg <= DBW_RUN;
    end else begin
      ib_addr_reg <= ib_addr_next;
      ib_ctl_reg <= ib_ctl_next;
      dw_a1_reg <= dw_a1_next;
      dw_a2_reg <= dw_a2_next;
      dw_ctl_reg <= dw_ctl_next;
      rw_mask_reg <= rw_mask_next;
      rw_val_reg <= rw_val_next;
      rw_ctl_reg <= rw_ctl_next;
      cause_reg <= cause_next;
      data_reg <= data_next;
      rdata_reg <= rdata_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      thr_reg <= thr_next;
      irq_reg <= irq_next;
      int_reg <= int_next;
      state_reg <= state_next;
    end
  end

  assign RDATA = rdata_reg;
  assign DBG_INT = irq_reg;
  // Halt code is bit 1 of the one-hot state, so the pin comes straight from a flop
  assign DBG_MODE = state_reg[1];
  assign DBG_THREAD = thr_reg;
  assign INT_OUT = int_reg;

  master_enable_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R2]
    !ib_ctl_reg[0][0] |-> !ib_hit[0]) else $error("disabled breakpoint fired");
  thread_enable_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R1]
    !dw_ctl_reg[1][16 + 32'(MEM_THREAD)] |-> !dw_hit[1]) else $error("thread not enabled yet hit");
  sense_invert_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R3]
    PC_VALID && ib_ctl_reg[0][1] && PC == ib_addr_reg[0] |-> !ib_hit[0]) else $error("inverted sense hit on equal");
  load_gate_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R6]
    MEM_LOAD && !dw_ctl_reg[0][2] |-> !dw_hit[0]) else $error("load hit while loads off");
  int_taken_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R10]
    state_reg == DBW_RUN && ib_hit != 4'h0 |=> DBG_INT && DBG_MODE ##1 !DBG_INT) else $error("no debug interrupt");
  cause_code_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R11]
    state_reg == DBW_RUN && ev == 3'h4 |=> cause_reg[2:0] == 3'h5 && DBG_THREAD == $past(RES_THREAD))
    else $error("wrong resource cause");
  low_index_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R12]
    state_reg == DBW_RUN && ev == 3'h1 && ib_hit == 4'hc |=> cause_reg[17:16] == 2'h2)
    else $error("wrong comparator index");
  data_capture_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R13]
    state_reg == DBW_RUN && ev == 3'h2 |=> data_reg == $past(MEM_ADDR)) else $error("address not captured");
endmodule : dbw_unit

// >>> bench/dbw_core_model.sv
// Core pipeline stand-in issuing one-cycle PC, memory and resource ops.
// Assumes the bench calls op from one process at a time.
`timescale 1ns/10ps
module dbw_core_model (
  input wire logic clk,
  output logic pc_valid,
  output dbw_pkg::dbw_word_type pc,
  output dbw_pkg::dbw_thread_type pc_thread,
  output logic mem_valid,
  output dbw_pkg::dbw_word_type mem_addr,
  output logic mem_load,
  output dbw_pkg::dbw_thread_type mem_thread,
  output logic res_valid,
  output dbw_pkg::dbw_word_type res_id,
  output dbw_pkg::dbw_thread_type res_thread
);
  import dbw_pkg::*;
  initial begin
    {pc_valid, mem_valid, res_valid, mem_load} = 4'h0;
    {pc, mem_addr, res_id} = '0;
    {pc_thread, mem_thread, res_thread} = '0;
  end
  task automatic op(input int k, input dbw_word_type a, input logic ld, input dbw_thread_type t);
    @(posedge clk);
    pc_valid <= (k == 0);
    mem_valid <= (k == 1);
    res_valid <= (k == 2);
    {pc, mem_addr, res_id} <= {3{a}};
    {pc_thread, mem_thread, res_thread} <= {3{t}};
    mem_load <= ld;
    @(posedge clk);
    {pc_valid, mem_valid, res_valid} <= 3'h0;
    // Idle lines show the inverse so a stale value never looks valid
    {pc, mem_addr, res_id} <= {3{~a}};
  endtask : op
endmodule : dbw_core_model

// >>> bench/test_dbw_unit.sv
// Self-checking bench for the break and watch unit.
// Assumes the core model drives the pipeline side.
`timescale 1ns/10ps
module test_dbw_unit;
  import dbw_pkg::*;
  logic REF_CLK, RST, WR, RD, PC_VALID, MEM_VALID, MEM_LOAD, RES_VALID, DBG_INT, DBG_MODE, INT_OUT;
  logic [7:0] ADDR;
  dbw_word_type WDATA, RDATA, PC, MEM_ADDR, RES_ID, r, p, a, b, m, v, id;
  dbw_thread_type PC_THREAD, MEM_THREAD, RES_THREAD, DBG_THREAD, t;
  logic [1:0] j;
  int n_fail = 0, compares = 0, cyc = 0, rs;
  logic [7:0] ca[3] = '{8'h40, 8'h70, 8'h9c};
  dbw_word_type cm[3] = '{32'h00ff0003, 32'h00ff0007, 32'h00ff0003};
  dbw_unit dut (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PC_VALID(PC_VALID), .PC(PC), .PC_THREAD(PC_THREAD), .MEM_VALID(MEM_VALID),
    .MEM_ADDR(MEM_ADDR), .MEM_LOAD(MEM_LOAD), .MEM_THREAD(MEM_THREAD), .RES_VALID(RES_VALID),
    .RES_ID(RES_ID), .RES_THREAD(RES_THREAD), .DBG_INT(DBG_INT), .DBG_MODE(DBG_MODE),
    .DBG_THREAD(DBG_THREAD), .INT_OUT(INT_OUT));
  dbw_core_model core (.clk(REF_CLK), .pc_valid(PC_VALID), .pc(PC), .pc_thread(PC_THREAD),
    .mem_valid(MEM_VALID), .mem_addr(MEM_ADDR), .mem_load(MEM_LOAD), .mem_thread(MEM_THREAD),
    .res_valid(RES_VALID), .res_id(RES_ID), .res_thread(RES_THREAD));
  initial begin
    REF_CLK = 1'b0;
    forever #10 REF_CLK = ~REF_CLK;
  end
  task results;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // Whole run needs about 230 cycles
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  task chk(input dbw_word_type e, input dbw_word_type g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] ad, input dbw_word_type d);
    @(posedge REF_CLK);
    ADDR <= ad;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] ad, output dbw_word_type d);
    @(posedge REF_CLK);
    ADDR <= ad;
    RD <= 1'b1;
    @(posedge REF_CLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd
  function automatic dbw_word_type ctlw(input dbw_thread_type th, input logic [7:0] f);
    return (32'h1 << (16 + th)) | {24'h0, f};
  endfunction : ctlw
  function automatic dbw_word_type expc(input logic [1:0] i, input dbw_thread_type th, input logic [2:0] c);
    return {14'h0, i, 5'h0, th, 5'h0, c};
  endfunction : expc
  // One op, then on a hit check capture, leave debug and clear status
  task fire(input int k, input dbw_word_type ad, input logic ld, input dbw_thread_type th,
            input logic e, input dbw_word_type ec, input dbw_word_type ed);
    core.op(k, ad, ld, th);
    #1 chk({30'h0, e, e}, {30'h0, DBG_INT, DBG_MODE});
    if (e) begin
      chk({29'h0, th}, {29'h0, DBG_THREAD});
      rd(8'h15, r);
      chk(ec, r);
      if (k > 0) rd(8'h16, r);
      if (k > 0) chk(ed, r);
      chk(32'h1, {31'h0, INT_OUT});
      wr(8'h15, 32'h0);
      wr(8'ha0, 32'h7);
      @(posedge REF_CLK);
      #1 chk(32'h0, {30'h0, INT_OUT, DBG_MODE});
    end
  endtask : fire
  initial begin
    rs = $urandom(74);
    {RST, WR, RD, ADDR, WDATA} = {1'b1, 42'h0};
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    foreach (ca[i]) begin
      rd(ca[i], r);
      chk(32'h0, r);
      wr(ca[i], 32'hffffffff);
      rd(ca[i], r);
      chk(cm[i], r);
      wr(ca[i], 32'h0);
    end
    rd(8'hff, r);
    chk(32'h0, r);
    wr(8'ha1, 32'h7);
    for (int i = 0; i < 4; i++) begin
      p = $urandom;
      t = 3'($urandom);
      wr(8'h30 + 8'(i), p);
      wr(8'h40 + 8'(i), ctlw(t, 8'h1));
      fire(0, p, 1'b0, t, 1'b1, expc(2'(i), t, 3'h3), 32'h0);
      wr(8'h40 + 8'(i), 32'h0);
    end
    wr(8'h30, p);
    wr(8'h40, ctlw(t, 8'h1));
    fire(0, p, 1'b0, t + 3'h1, 1'b0, 32'h0, 32'h0);
    wr(8'h40, ctlw(t, 8'h0));
    fire(0, p, 1'b0, t, 1'b0, 32'h0, 32'h0);
    wr(8'h40, ctlw(t, 8'h3));
    fire(0, p, 1'b0, t, 1'b0, 32'h0, 32'h0);
    fire(0, p + 32'h1, 1'b0, t, 1'b1, expc(2'h0, t, 3'h3), 32'h0);
    wr(8'h32, p);
    wr(8'h33, p);
    wr(8'h43, ctlw(t, 8'h1));
    wr(8'h42, ctlw(t, 8'h1));
    wr(8'h40, 32'h0);
    fire(0, p, 1'b0, t, 1'b1, expc(2'h2, t, 3'h3), 32'h0);
    wr(8'h42, 32'h0);
    wr(8'h43, 32'h0);
    j = 2'($urandom);
    a = $urandom;
    b = ~a;
    wr(8'h50 + j, a);
    wr(8'h60 + j, b);
    rd(8'h50 + j, r);
    chk(a, r);
    wr(8'h70 + j, ctlw(t, 8'h3));
    fire(1, b, 1'b0, t, 1'b1, expc(j, t, 3'h4), b);
    fire(1, a, 1'b1, t, 1'b0, 32'h0, 32'h0);
    wr(8'h70 + j, ctlw(t, 8'h7));
    fire(1, a, 1'b1, t, 1'b1, expc(j, t, 3'h4), a);
    wr(8'h70 + j, ctlw(t, 8'h5));
    fire(1, a, 1'b1, t, 1'b0, 32'h0, 32'h0);
    wr(8'h60 + j, a);
    fire(1, a, 1'b1, t, 1'b1, expc(j, t, 3'h4), a);
    wr(8'h70 + j, 32'h0);
    m = $urandom | 32'h1;
    v = $urandom;
    id = v ^ ~m;
    wr(8'h80 + j, m);
    wr(8'h90 + j, v);
    rd(8'h80 + j, r);
    chk(m, r);
    wr(8'h9c + j, ctlw(t, 8'h1));
    fire(2, id, 1'b0, t, 1'b1, expc(j, t, 3'h5), id);
    fire(2, id ^ 32'h1, 1'b0, t, 1'b0, 32'h0, 32'h0);
    wr(8'h9c + j, ctlw(t, 8'h3));
    fire(2, id ^ 32'h1, 1'b0, t, 1'b1, expc(j, t, 3'h5), id ^ 32'h1);
    fire(2, id, 1'b0, t, 1'b0, 32'h0, 32'h0);
    // Mid-run reset must clear the armed control word again
    @(posedge REF_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    rd(8'h9c + j, r);
    chk(32'h0, r);
    fire(2, id ^ 32'h1, 1'b0, t, 1'b0, 32'h0, 32'h0);
    results();
  end
endmodule : test_dbw_unit
